/* rtl/canmo_pkg.sv */
//  Contract
// - no interrupt without global enable
// - only enabled sources reach interrupt output
// - object interrupt needs its direction enable
// - error source on bus-off or warning limit
// - status source on transfer done, bus error
// - status cause reads status cause code
// - status register read clears status pending
// - cause gives highest-priority pending object 1-32
// - clear command or message read clears pending
// - bitmap register shows pending objects
// - thirty-two configurable message objects
// - invalid object never transfers nor interrupts
// - fresh flag set on store, cleared on read
// - overrun flag on unread overwrite
// - five object types, auto reply included
// - standard or extended identifier per object
// - masked identifier compare when filtering enabled
// - separate tx and rx interrupt enables
// - eight data bytes per object
// - configuration write replaces whole object
// - controller disabled after reset
package canmo_pkg;

  localparam int NOBJ  = 32;
  localparam int OBJ_W = 5;

  // ==========================================================
  // register offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_CAUSE  = 8'h08;
  localparam logic [7:0] OFS_PEND   = 8'h0c;
  localparam logic [7:0] OFS_CMD    = 8'h10;
  localparam logic [7:0] OFS_ARB    = 8'h14;
  localparam logic [7:0] OFS_MASK   = 8'h18;
  localparam logic [7:0] OFS_MCTL   = 8'h1c;
  localparam logic [7:0] OFS_DLO    = 8'h20;
  localparam logic [7:0] OFS_DHI    = 8'h24;
  localparam logic [7:0] OFS_VALID  = 8'h28;
  localparam logic [7:0] OFS_FRESH  = 8'h2c;
  localparam logic [7:0] OFS_TXREQ  = 8'h30;

  // ==========================================================
  // field positions and reset values
  localparam int CTRL_EN_BIT    = 0;
  localparam int CTRL_GIE_BIT   = 1;
  localparam int CTRL_ERRIE_BIT = 2;
  localparam int CTRL_STIE_BIT  = 3;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam int STS_LEC_LSB    = 0;
  localparam int STS_TXOK_BIT   = 3;
  localparam int STS_RXOK_BIT   = 4;
  localparam int STS_EPASS_BIT  = 5;
  localparam int STS_EWARN_BIT  = 6;
  localparam int STS_BOFF_BIT   = 7;
  localparam int CMD_OBJ_LSB    = 0;
  localparam int CMD_OP_LSB     = 8;
  localparam int ARB_EXT_BIT    = 29;
  localparam int ARB_VALID_BIT  = 31;
  localparam int MCTL_LEN_LSB   = 0;
  localparam int MCTL_TYPE_LSB  = 4;
  localparam int MCTL_TXIE_BIT  = 8;
  localparam int MCTL_RXIE_BIT  = 9;
  localparam int MCTL_FILT_BIT  = 10;
  localparam int MCTL_FRESH_BIT = 12;
  localparam int MCTL_OVR_BIT   = 13;
  localparam logic [15:0] STATUS_CAUSE_CODE = 16'h8000;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ==========================================================
  // types
  typedef enum logic [2:0] {
    transmit_object                = 3'b000,
    transmit_remote_request_object = 3'b001,
    receive_object                 = 3'b010,
    receive_remote_request_object  = 3'b011,
    auto_reply_object              = 3'b100
  } canmo_type_t;

  typedef enum logic [1:0] {
    OP_INVALIDATE = 2'b00,
    OP_WRITE      = 2'b01,
    OP_READ       = 2'b10,
    OP_CLEAR      = 2'b11
  } canmo_op_t;

  typedef struct packed {
    logic [28:0] id;
    logic        ext;
    logic        rtr;
    logic [3:0]  dlc;
    logic [63:0] data;
  } canmo_frame_t;

  typedef struct packed {
    logic        bus_off;
    logic        ewarn;
    logic        epass;
    logic        tx_ok;
    logic        rx_ok;
    logic        lec_valid;
    logic [2:0]  lec;
  } canmo_evt_t;

  typedef struct packed {
    logic [28:0] id;
    logic        ext;
    logic [28:0] mask;
    logic [3:0]  dlc;
    canmo_type_t typ;
    logic        tx_done_irq_enable;
    logic        rx_done_irq_enable;
    logic        id_mask_filter_enable;
  } canmo_cfg_t;

endpackage

/* rtl/canmo_prio.sv */
module canmo_prio #(
  parameter int N = 32,
  parameter int W = 5
) (
  input  wire logic [N-1:0] req,
  output logic              found,
  output logic [W-1:0]      idx
);

  if (N > (1 << W)) begin : g_chk
    $error("canmo_prio: index too narrow");
  end

  // lowest index wins
  always_comb begin
    found = 1'b0;
    idx   = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        found = 1'b1;
        idx   = W'(i);
      end
    end
  end

endmodule

/* rtl/canmo_top.sv */
// Implementation choices: the register offsets and the AXI4-Lite slave port.
module canmo_top #(
  parameter int ADDR_W = 8
) (
  input  wire logic                    clock,
  input  wire logic                    rst_n,
  input  wire logic [ADDR_W-1:0]       awaddr,
  input  wire logic                    awvalid,
  output logic                         awready,
  input  wire logic [31:0]             wdata,
  input  wire logic [3:0]              wstrb,
  input  wire logic                    wvalid,
  output logic                         wready,
  output logic [1:0]                   bresp,
  output logic                         bvalid,
  input  wire logic                    bready,
  input  wire logic [ADDR_W-1:0]       araddr,
  input  wire logic                    arvalid,
  output logic                         arready,
  output logic [31:0]                  rdata,
  output logic [1:0]                   rresp,
  output logic                         rvalid,
  input  wire logic                    rready,
  input  wire logic                    rx_valid,
  input  wire canmo_pkg::canmo_frame_t rx_frame,
  input  wire logic                    tx_done,
  input  wire logic [4:0]              tx_done_idx,
  input  wire logic [4:0]              tx_sel,
  input  wire canmo_pkg::canmo_evt_t   evt,
  output canmo_pkg::canmo_frame_t      tx_frame,
  output logic [31:0]                  tx_pend,
  output logic                         ctrl_enable,
  output logic                         irq
);
  import canmo_pkg::*;

  if (ADDR_W < 8) begin : g_chk
    $error("canmo_top: address too narrow for register map");
  end

  // ==========================================================
  // helpers
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) old[8*b +: 8] = nw[8*b +: 8];
    end
    return old;
  endfunction

  function automatic logic [31:0] onehot(input logic [OBJ_W-1:0] i);
    return 32'h0000_0001 << i;
  endfunction

  function automatic logic id_hit(input canmo_cfg_t c, input canmo_frame_t f);
    logic [28:0] diff;
    logic [28:0] keep;
    diff = c.id ^ f.id;
    keep = c.ext ? 29'h1fff_ffff : 29'h0000_07ff;
    if (c.id_mask_filter_enable) keep = keep & c.mask;
    return (c.ext == f.ext) && ((diff & keep) == 29'h0000_0000);
  endfunction

  function automatic logic takes_data(input canmo_type_t t);
    return (t == receive_object) || (t == transmit_remote_request_object);
  endfunction

  function automatic logic takes_remote(input canmo_type_t t);
    return (t == receive_remote_request_object) || (t == auto_reply_object);
  endfunction

  // ==========================================================
  // storage
  canmo_cfg_t     cfg_mem  [NOBJ];
  logic [63:0]    data_mem [NOBJ];
  logic [31:0]    valid_r;
  logic [31:0]    fresh_r;
  logic [31:0]    ovr_r;
  logic [31:0]    pend_r;
  logic [31:0]    ctrl_r;
  logic [7:0]     sts_r;
  logic           st_pend_r;
  logic           err_pend_r;
  logic           boff_prev_r;
  logic           ewarn_prev_r;
  logic [15:0]    cause_r;
  logic [OBJ_W-1:0] sel_r;
  logic [31:0]    stg_arb_r;
  logic [31:0]    stg_mask_r;
  logic [31:0]    stg_mctl_r;
  logic [31:0]    stg_dlo_r;
  logic [31:0]    stg_dhi_r;

  logic              aw_got_r;
  logic              w_got_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic [31:0]       w_data_r;
  logic [3:0]        w_strb_r;
  logic              wr_fire;
  logic              rd_fire;
  logic [31:0]       rd_data;
  logic              rd_ok;
  logic              wr_ok;

  // ==========================================================
  // axi4-lite handshakes
  assign wr_fire = aw_got_r && w_got_r && !bvalid;
  assign rd_fire = arvalid && arready;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      awready   <= 1'b1;
      wready    <= 1'b1;
      aw_got_r  <= 1'b0;
      w_got_r   <= 1'b0;
      aw_addr_r <= '0;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
      bvalid    <= 1'b0;
      bresp     <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_got_r  <= 1'b1;
        aw_addr_r <= awaddr;
        awready   <= 1'b0;
      end
      if (wvalid && wready) begin
        w_got_r  <= 1'b1;
        w_data_r <= wdata;
        w_strb_r <= wstrb;
        wready   <= 1'b0;
      end
      if (wr_fire) begin
        aw_got_r <= 1'b0;
        w_got_r  <= 1'b0;
        bvalid   <= 1'b1;
        bresp    <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= RESP_OKAY;
    end else begin
      if (rd_fire) begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rdata   <= rd_data;
        rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  // ==========================================================
  // address decode
  logic [7:0] wa;
  logic [7:0] ra;
  assign wa = aw_addr_r[7:0];
  assign ra = araddr[7:0];

  always_comb begin
    wr_ok = (wa == OFS_CTRL) || (wa == OFS_CMD) || (wa == OFS_ARB) || (wa == OFS_MASK)
            || (wa == OFS_MCTL) || (wa == OFS_DLO) || (wa == OFS_DHI);
  end

  always_comb begin
    rd_ok   = 1'b1;
    rd_data = 32'h0000_0000;
    if (ra == OFS_CTRL) begin
      rd_data = ctrl_r;
    end else if (ra == OFS_STATUS) begin
      rd_data = {24'h00_0000, sts_r};
    end else if (ra == OFS_CAUSE) begin
      rd_data = {16'h0000, cause_r};
    end else if (ra == OFS_PEND) begin
      rd_data = pend_r;
    end else if (ra == OFS_CMD) begin
      rd_data = {27'h000_0000, sel_r} + 32'h0000_0001;
    end else if (ra == OFS_ARB) begin
      rd_data = stg_arb_r;
    end else if (ra == OFS_MASK) begin
      rd_data = stg_mask_r;
    end else if (ra == OFS_MCTL) begin
      rd_data = stg_mctl_r;
      rd_data[MCTL_FRESH_BIT] = fresh_r[sel_r];
      rd_data[MCTL_OVR_BIT]   = ovr_r[sel_r];
    end else if (ra == OFS_DLO) begin
      rd_data = stg_dlo_r;
    end else if (ra == OFS_DHI) begin
      rd_data = stg_dhi_r;
    end else if (ra == OFS_VALID) begin
      rd_data = valid_r;
    end else if (ra == OFS_FRESH) begin
      rd_data = fresh_r;
    end else if (ra == OFS_TXREQ) begin
      rd_data = tx_pend;
    end else begin
      rd_ok = 1'b0;
    end
  end

  // ==========================================================
  // host commands
  logic             cmd_wr;
  logic [5:0]       cmd_num;
  logic [OBJ_W-1:0] cmd_idx;
  canmo_op_t        cmd_op;
  logic             cmd_go;
  canmo_cfg_t       stg_cfg;
  logic             sts_rd;

  assign cmd_wr  = wr_fire && (wa == OFS_CMD) && w_strb_r[0];
  assign cmd_num = w_data_r[CMD_OBJ_LSB +: 6];
  assign cmd_idx = OBJ_W'(cmd_num - 6'h01);
  assign cmd_op  = canmo_op_t'(w_data_r[CMD_OP_LSB +: 2]);
  assign cmd_go  = cmd_wr && (cmd_num != 6'h00) && (cmd_num <= 6'(NOBJ));
  assign sts_rd  = rd_fire && (ra == OFS_STATUS);

  always_comb begin
    stg_cfg.id                    = stg_arb_r[28:0];
    stg_cfg.ext                   = stg_arb_r[ARB_EXT_BIT];
    stg_cfg.mask                  = stg_mask_r[28:0];
    stg_cfg.dlc                   = stg_mctl_r[MCTL_LEN_LSB +: 4];
    stg_cfg.typ                   = canmo_type_t'(stg_mctl_r[MCTL_TYPE_LSB +: 3]);
    stg_cfg.tx_done_irq_enable    = stg_mctl_r[MCTL_TXIE_BIT];
    stg_cfg.rx_done_irq_enable    = stg_mctl_r[MCTL_RXIE_BIT];
    stg_cfg.id_mask_filter_enable = stg_mctl_r[MCTL_FILT_BIT];
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= CTRL_RST;
    end else if (wr_fire && (wa == OFS_CTRL)) begin
      ctrl_r <= wmerge(ctrl_r, w_data_r, w_strb_r) & 32'h0000_000f;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sel_r      <= '0;
      stg_arb_r  <= 32'h0000_0000;
      stg_mask_r <= 32'h0000_0000;
      stg_mctl_r <= 32'h0000_0000;
      stg_dlo_r  <= 32'h0000_0000;
      stg_dhi_r  <= 32'h0000_0000;
    end else if (cmd_go && (cmd_op == OP_READ)) begin
      sel_r      <= cmd_idx;
      stg_arb_r  <= {valid_r[cmd_idx], 1'b0, cfg_mem[cmd_idx].ext, cfg_mem[cmd_idx].id};
      stg_mask_r <= {3'h0, cfg_mem[cmd_idx].mask};
      stg_mctl_r <= {21'h00_0000, cfg_mem[cmd_idx].id_mask_filter_enable,
                     cfg_mem[cmd_idx].rx_done_irq_enable, cfg_mem[cmd_idx].tx_done_irq_enable,
                     1'b0, cfg_mem[cmd_idx].typ, cfg_mem[cmd_idx].dlc};
      stg_dlo_r  <= data_mem[cmd_idx][31:0];
      stg_dhi_r  <= data_mem[cmd_idx][63:32];
    end else begin
      if (cmd_go) sel_r <= cmd_idx;
      if (wr_fire && (wa == OFS_ARB)) stg_arb_r <= wmerge(stg_arb_r, w_data_r, w_strb_r);
      if (wr_fire && (wa == OFS_MASK)) stg_mask_r <= wmerge(stg_mask_r, w_data_r, w_strb_r);
      if (wr_fire && (wa == OFS_MCTL)) stg_mctl_r <= wmerge(stg_mctl_r, w_data_r, w_strb_r);
      if (wr_fire && (wa == OFS_DLO)) stg_dlo_r <= wmerge(stg_dlo_r, w_data_r, w_strb_r);
      if (wr_fire && (wa == OFS_DHI)) stg_dhi_r <= wmerge(stg_dhi_r, w_data_r, w_strb_r);
    end
  end

  // ==========================================================
  // receive matching
  logic [31:0]      rx_hit;
  logic             rx_found;
  logic [OBJ_W-1:0] rx_idx;
  logic             rx_ev;

  always_comb begin
    for (int i = 0; i < NOBJ; i++) begin
      rx_hit[i] = valid_r[i] && id_hit(cfg_mem[i], rx_frame)
                  && (rx_frame.rtr ? takes_remote(cfg_mem[i].typ)
                                   : takes_data(cfg_mem[i].typ));
    end
  end

  canmo_prio #(.N(NOBJ), .W(OBJ_W)) u_rx_prio (
    .req   (rx_hit),
    .found (rx_found),
    .idx   (rx_idx)
  );

  assign rx_ev = rx_valid && ctrl_r[CTRL_EN_BIT] && rx_found;

  always_ff @(posedge clock) begin
    if (cmd_go && (cmd_op == OP_WRITE)) begin
      cfg_mem[cmd_idx]  <= stg_cfg;
      data_mem[cmd_idx] <= {stg_dhi_r, stg_dlo_r};
    end else if (rx_ev && !rx_frame.rtr) begin
      data_mem[rx_idx]    <= rx_frame.data;
      cfg_mem[rx_idx].dlc <= rx_frame.dlc;
    end
  end

  // ==========================================================
  // per-object flags
  logic [31:0] host_oh;
  logic [31:0] rx_oh;
  logic [31:0] txd_oh;
  logic [31:0] valid_nxt;
  logic [31:0] pend_set;
  logic [31:0] pend_clr;
  logic [31:0] fresh_set;
  logic [31:0] fresh_clr;
  logic [31:0] txp_set;
  logic        txd_ok;

  assign host_oh = cmd_go ? onehot(cmd_idx) : 32'h0000_0000;
  assign rx_oh   = rx_ev ? onehot(rx_idx) : 32'h0000_0000;
  assign txd_ok  = tx_done && ctrl_r[CTRL_EN_BIT] && valid_r[tx_done_idx];
  assign txd_oh  = txd_ok ? onehot(tx_done_idx) : 32'h0000_0000;

  always_comb begin
    valid_nxt = valid_r;
    pend_clr  = 32'h0000_0000;
    fresh_clr = 32'h0000_0000;
    txp_set   = 32'h0000_0000;
    pend_set  = 32'h0000_0000;
    fresh_set = 32'h0000_0000;
    if (cmd_op == OP_INVALIDATE) valid_nxt = valid_r & ~host_oh;
    if (cmd_op == OP_WRITE) begin
      valid_nxt = stg_arb_r[ARB_VALID_BIT] ? (valid_r | host_oh) : (valid_r & ~host_oh);
      pend_clr  = host_oh;
      fresh_clr = host_oh;
      if (stg_cfg.typ == transmit_object || stg_cfg.typ == transmit_remote_request_object) begin
        txp_set = host_oh;
      end
    end
    // clear command or read of received message
    if (cmd_op == OP_CLEAR) pend_clr = host_oh;
    if (cmd_op == OP_READ) begin
      fresh_clr = host_oh;
      if (takes_data(cfg_mem[cmd_idx].typ) || takes_remote(cfg_mem[cmd_idx].typ)) begin
        pend_clr = host_oh;
      end
    end
    if (!rx_frame.rtr || cfg_mem[rx_idx].typ == receive_remote_request_object) begin
      fresh_set = rx_oh;
    end
    if (cfg_mem[rx_idx].rx_done_irq_enable) pend_set = rx_oh;
    if (cfg_mem[tx_done_idx].tx_done_irq_enable) pend_set = pend_set | txd_oh;
    if (rx_frame.rtr && cfg_mem[rx_idx].typ == auto_reply_object) txp_set = txp_set | rx_oh;
  end

  // set wins over clear; invalid objects hold no pending or transmit request
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      valid_r <= 32'h0000_0000;
      pend_r  <= 32'h0000_0000;
      fresh_r <= 32'h0000_0000;
      ovr_r   <= 32'h0000_0000;
      tx_pend <= 32'h0000_0000;
    end else begin
      valid_r <= valid_nxt;
      pend_r  <= ((pend_r & ~pend_clr) | pend_set) & valid_nxt;
      fresh_r <= (fresh_r & ~fresh_clr) | fresh_set;
      ovr_r   <= (ovr_r & ~fresh_clr) | (fresh_set & fresh_r);
      tx_pend <= ((tx_pend & ~txd_oh & ~host_oh) | txp_set) & valid_nxt;
    end
  end

  // ==========================================================
  // controller status and error sources
  logic st_ev;
  logic err_ev;

  assign st_ev  = evt.tx_ok || evt.rx_ok || (evt.lec_valid && (evt.lec != 3'h0));
  assign err_ev = (evt.bus_off && !boff_prev_r) || (evt.ewarn && !ewarn_prev_r);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sts_r        <= 8'h00;
      st_pend_r    <= 1'b0;
      err_pend_r   <= 1'b0;
      boff_prev_r  <= 1'b0;
      ewarn_prev_r <= 1'b0;
    end else begin
      boff_prev_r  <= evt.bus_off;
      ewarn_prev_r <= evt.ewarn;
      sts_r[STS_BOFF_BIT]  <= evt.bus_off;
      sts_r[STS_EWARN_BIT] <= evt.ewarn;
      sts_r[STS_EPASS_BIT] <= evt.epass;
      sts_r[STS_TXOK_BIT]  <= evt.tx_ok || (sts_r[STS_TXOK_BIT] && !sts_rd);
      sts_r[STS_RXOK_BIT]  <= evt.rx_ok || (sts_r[STS_RXOK_BIT] && !sts_rd);
      if (evt.lec_valid) sts_r[STS_LEC_LSB +: 3] <= evt.lec;
      // status read clears pending, new event wins
      st_pend_r  <= st_ev || (st_pend_r && !sts_rd);
      err_pend_r <= err_ev || (err_pend_r && !sts_rd);
    end
  end

  // ==========================================================
  // cause and interrupt output
  logic             obj_found;
  logic [OBJ_W-1:0] obj_idx;

  canmo_prio #(.N(NOBJ), .W(OBJ_W)) u_cause_prio (
    .req   (pend_r),
    .found (obj_found),
    .idx   (obj_idx)
  );

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cause_r <= 16'h0000;
    end else if (st_pend_r) begin
      cause_r <= STATUS_CAUSE_CODE;
    end else if (obj_found) begin
      cause_r <= 16'(obj_idx) + 16'h0001;
    end else begin
      cause_r <= 16'h0000;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq         <= 1'b0;
      ctrl_enable <= 1'b0;
      tx_frame    <= '0;
    end else begin
      ctrl_enable <= ctrl_r[CTRL_EN_BIT];
      irq <= ctrl_r[CTRL_GIE_BIT] && ((ctrl_r[CTRL_ERRIE_BIT] && err_pend_r)
             || (ctrl_r[CTRL_STIE_BIT] && st_pend_r) || (pend_r != 32'h0000_0000));
      tx_frame.id   <= cfg_mem[tx_sel].id;
      tx_frame.ext  <= cfg_mem[tx_sel].ext;
      tx_frame.rtr  <= (cfg_mem[tx_sel].typ == transmit_remote_request_object);
      tx_frame.dlc  <= cfg_mem[tx_sel].dlc;
      tx_frame.data <= data_mem[tx_sel];
    end
  end

endmodule

/* verif/canmo_asserts.sv */
module canmo_asserts
  import canmo_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic              clock,
  input wire logic              rst_n,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic              awvalid,
  input wire logic              awready,
  input wire logic [31:0]       wdata,
  input wire logic [3:0]        wstrb,
  input wire logic              wvalid,
  input wire logic              wready,
  input wire logic              bvalid,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic              arvalid,
  input wire logic              arready,
  input wire logic [31:0]       rdata,
  input wire logic              rvalid,
  input wire logic              ctrl_enable,
  input wire logic              irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic              gie_sh_r;
  logic [ADDR_W-1:0] rd_addr_r;
  wire               wr_take = awvalid && awready && wvalid && wready;
  wire               wr_ctrl = wr_take && awaddr == ADDR_W'(OFS_CTRL) && wstrb[0];

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // ==========================================================
  // shadow of the global enable and read address
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      gie_sh_r <= 1'b0;
    end else if (wr_ctrl) begin
      gie_sh_r <= wdata[CTRL_GIE_BIT];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rd_addr_r <= '0;
    end else if (arvalid && arready) begin
      rd_addr_r <= araddr;
    end
  end

  // ==========================================================
  // bus handshakes, interrupt gating, enable and cause checks
  wr_answer_a: assert property (wr_take |=> ##1 bvalid)
    else $error("write response late");
  wr_busy_a: assert property (bvalid |-> !awready && !wready)
    else $error("write accepted during response");
  wr_free_a: assert property ($fell(bvalid) |-> awready && wready)
    else $error("write channel not reopened");
  rd_answer_a: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read response late");
  gie_gate_a: assert property (!gie_sh_r [*4] |-> !irq)
    else $error("interrupt without global enable");
  en_follow_a: assert property (wr_ctrl |-> ##3 ctrl_enable == $past(wdata[0], 3))
    else $error("controller enable mismatch");
  cause_range_a: assert property (rvalid && rd_addr_r == ADDR_W'(OFS_CAUSE)
      |-> rdata == {16'h0000, STATUS_CAUSE_CODE} || rdata <= 32'h0000_0020)
    else $error("cause value out of range");
  irq_hold_a: assert property ($fell(irq) |-> $past(bvalid) || $past(rvalid)
      || $past(bvalid, 2) || $past(rvalid, 2))
    else $error("interrupt dropped without host access");
endmodule

bind canmo_top canmo_asserts #(.ADDR_W(ADDR_W)) canmo_asserts_inst (
  .clock, .rst_n, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bvalid,
  .araddr, .arvalid, .arready, .rdata, .rvalid, .ctrl_enable, .irq
);

/* verif/canmo_engine.sv */
module canmo_engine (
  input  wire logic             clock,
  output logic                  rx_valid,
  output canmo_pkg::canmo_frame_t rx_frame,
  output logic                  tx_done,
  output logic [4:0]            tx_done_idx,
  output logic [4:0]            tx_sel,
  output canmo_pkg::canmo_evt_t evt
);
  timeunit 1ns;
  timeprecision 1ps;
  import canmo_pkg::*;

  initial begin
    rx_valid = 1'b0;
    rx_frame = '0;
    tx_done = 1'b0;
    tx_done_idx = 5'h0;
    tx_sel = 5'h1;
    evt = '0;
  end

  task automatic rx(input logic [28:0] id, input logic [63:0] d);
    rx_frame <= '{id: id, ext: 1'b0, rtr: 1'b0, dlc: 4'h8, data: d};
    rx_valid <= 1'b1;
    @(posedge clock);
    rx_valid <= 1'b0;
    rx_frame <= canmo_frame_t'(~rx_frame);
  endtask

  task automatic done(input logic [4:0] idx);
    tx_done_idx <= idx;
    tx_done <= 1'b1;
    @(posedge clock);
    tx_done <= 1'b0;
    tx_done_idx <= ~idx;
  endtask

  task automatic ok();
    evt.tx_ok <= 1'b1;
    @(posedge clock);
    evt.tx_ok <= 1'b0;
  endtask

  task automatic boff(input logic v);
    evt.bus_off <= v;
    @(posedge clock);
  endtask
endmodule

/* verif/canmo_bench.sv */
module canmo_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import canmo_pkg::*;

  logic         clock, rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic         awready, wready, bvalid, arready, rvalid;
  logic         rx_valid, tx_done, ctrl_enable, irq;
  logic [7:0]   awaddr, araddr;
  logic [1:0]   bresp, rresp;
  logic [4:0]   tx_done_idx, tx_sel;
  logic [31:0]  wdata, rdata, tx_pend;
  canmo_frame_t rx_frame, tx_frame;
  canmo_evt_t   evt;
  int           err_total, checks_done;

  canmo_top canmo_top_inst (
    .clock, .rst_n, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hf), .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .rx_valid, .rx_frame, .tx_done, .tx_done_idx, .tx_sel, .evt, .tx_frame, .tx_pend,
    .ctrl_enable, .irq
  );
  canmo_engine eng (.clock, .rx_valid, .rx_frame, .tx_done, .tx_done_idx, .tx_sel, .evt);

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // ==========================================================
  // checking and bus tasks
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask

  task automatic chk_irq(input logic e);
    chk({31'h0, irq}, {31'h0, e});
  endtask

  task automatic step(inout int n);
    @(posedge clock);
    n++;
    if (n > 60) begin
      err_total++;
      $display("unexpected at %0t: wait limit", $time);
      close_out();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
    int n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      step(n);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (awvalid || wvalid);
    while (!bvalid) step(n);
    chk({30'h0, bresp}, {30'h0, er});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
    int n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    step(n);
    while (!arready) step(n);
    arvalid <= 1'b0;
    step(n);
    while (!rvalid) step(n);
    chk(rdata, e);
    chk({30'h0, rresp}, {30'h0, er});
  endtask

  task automatic cfg(input logic [5:0] n, input logic [31:0] arb, input logic [31:0] mctl);
    wr(OFS_ARB, arb);
    wr(OFS_MASK, 32'h0000_07ff);
    wr(OFS_MCTL, mctl);
    wr(OFS_CMD, {22'h0, 2'h1, 2'h0, n});
  endtask

  // ==========================================================
  // test sequence
  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    err_total = 0;
    checks_done = 0;
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    rd(OFS_CTRL, 32'h0);
    rd(OFS_PEND, 32'h0);
    cfg(6'd1, 32'h8000_0123, 32'h0000_0628);
    cfg(6'd2, 32'h8000_0124, 32'h0000_0428);
    wr(OFS_CTRL, 32'h0000_0003);
    eng.rx(29'h124, 64'h1);
    repeat (3) @(posedge clock);
    chk_irq(1'b0);
    rd(OFS_FRESH, 32'h2);
    eng.rx(29'h123, 64'h0807_0605_0403_0201);
    repeat (3) @(posedge clock);
    chk_irq(1'b1);
    rd(OFS_CAUSE, 32'h1);
    rd(OFS_PEND, 32'h1);
    wr(OFS_CMD, 32'h0000_0201);
    rd(OFS_DHI, 32'h0807_0605);
    rd(OFS_PEND, 32'h0);
    $display("test receive done");
    wr(OFS_CTRL, 32'h0000_0001);
    eng.rx(29'h123, 64'h0);
    repeat (3) @(posedge clock);
    chk_irq(1'b0);
    eng.rx(29'h123, 64'h0);
    wr(OFS_CTRL, 32'h0000_0003);
    repeat (2) @(posedge clock);
    chk_irq(1'b1);
    wr(OFS_CMD, 32'h0000_0301);
    repeat (2) @(posedge clock);
    chk_irq(1'b0);
    rd(OFS_MCTL, 32'h0000_3628);
    $display("test gating done");
    wr(OFS_CTRL, 32'h0000_000b);
    eng.ok();
    repeat (3) @(posedge clock);
    rd(OFS_CAUSE, 32'h0000_8000);
    chk_irq(1'b1);
    rd(OFS_STATUS, 32'h0000_0008);
    repeat (2) @(posedge clock);
    chk_irq(1'b0);
    wr(OFS_CTRL, 32'h0000_0007);
    eng.boff(1'b1);
    repeat (3) @(posedge clock);
    chk_irq(1'b1);
    rd(OFS_STATUS, 32'h0000_0080);
    repeat (2) @(posedge clock);
    chk_irq(1'b0);
    eng.boff(1'b0);
    $display("test sources done");
    wr(OFS_CMD, 32'h0000_0001);
    rd(OFS_VALID, 32'h2);
    eng.rx(29'h123, 64'h0);
    repeat (3) @(posedge clock);
    rd(OFS_PEND, 32'h0);
    rd(8'h40, 32'h0, RESP_SLVERR);
    wr(OFS_PEND, 32'hffff_ffff, RESP_SLVERR);
    cfg(6'd2, 32'h8000_0055, 32'h0000_0108);
    rd(OFS_FRESH, 32'h1);
    chk(tx_pend, 32'h2);
    chk({3'h0, tx_frame.id}, 32'h55);
    eng.done(5'h1);
    repeat (3) @(posedge clock);
    chk_irq(1'b1);
    rd(OFS_CAUSE, 32'h2);
    $display("test objects done");
    close_out();
  end
endmodule
